/* File: shared/spsi_pkg.sv */
// Shared constants and types for the serial port select and two-wire slave
package spsi_pkg;

  // Three-level select pin codes, as delivered by the pin receivers
  localparam logic [1:0] PIN_LOW  = 2'h0;
  localparam logic [1:0] PIN_OPEN = 2'h1;
  localparam logic [1:0] PIN_HIGH = 2'h2;

  // Slave address
  localparam int         SLAVE_ADDR_W   = 7;
  localparam logic [3:0] SLAVE_ADDR_TOP = 4'hb;

  // Byte framing
  localparam int         BYTE_W    = 8;
  localparam logic [2:0] FIRST_BIT = 3'h0;
  localparam logic [2:0] LAST_BIT  = 3'h7;

  // Register address and storage
  localparam int          REG_ADDR_W     = 16;
  localparam int          CFG_ADDR_W_DEF = 10;
  localparam logic [7:0]  CFG_RESET_VAL  = 8'h00;
  localparam logic [15:0] PTR_RESET      = 16'h0000;

  // Byte index within a write transfer
  localparam logic [1:0] IDX_ADDR_HI = 2'h0;
  localparam logic [1:0] IDX_ADDR_LO = 2'h1;
  localparam logic [1:0] IDX_DATA    = 2'h2;

  // Bus rates and crossing budget
  localparam int STD_RATE_KHZ  = 100;
  localparam int FAST_RATE_KHZ = 400;
  localparam int CLK_RATE_KHZ  = 100000;
  localparam int FAST_HALF_CYC = CLK_RATE_KHZ / (2 * FAST_RATE_KHZ);
  localparam int FETCH_LAT_CYC = 4;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_ACK  = 6'h04,
    ST_RX   = 6'h08,
    ST_TX   = 6'h10,
    ST_MACK = 6'h20
  } spsi_state_t;

endpackage

/* File: core/spsi_sync.sv */
// Two-flop level synchroniser
`timescale 1ns/1ns
module spsi_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Levels
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;

  if (WIDTH < 1)
  begin : g_chk
    $error("spsi_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= '0;
      q      <= '0;
    end
    else
    begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

/* File: core/spsi_cfg_mem.sv */
// Configuration register storage with registered read port
`timescale 1ns/1ns
module spsi_cfg_mem #(
  parameter int ADDR_W = spsi_pkg::CFG_ADDR_W_DEF
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Write port
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [7:0]        wr_data,
  // Read port
  input  wire logic              rd_en,
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [7:0]        rd_data
);

  localparam int DEPTH = 1 << ADDR_W;

  logic [7:0] mem_q [DEPTH];

  if (ADDR_W < 1 || ADDR_W > spsi_pkg::REG_ADDR_W)
  begin : g_chk
    $error("spsi_cfg_mem: ADDR_W out of range");
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_q[i] <= spsi_pkg::CFG_RESET_VAL;
    end
    else if (wr_en)
    begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rd_data <= spsi_pkg::CFG_RESET_VAL;
    else if (rd_en)
      rd_data <= mem_q[rd_addr];
  end

endmodule

/* File: core/spsi_serial_port.sv */
// Serial port select and two-wire register slave
//
// Functional notes
// R1: Four-wire port only when both select pins read high; else two-wire.
// R2: Slave address is 1011 plus three bits from the select pin pair.
// R3: Slave works at standard and fast bus rates.
// R4: Device is slave only and never drives the clock line.
// R5: Register address is sixteen bits, sent as two bytes.
// R6: One clock pulse per data bit; one bit sampled per pulse.
// R7: Data line changes only while clock low, stable while high.
// R8: Master begins with start; slave restarts its bit counter.
// R9: Master ends with stop; slave goes back to idle.
// R10: Bytes are eight bits, most significant bit first.
// R11: Receiver acknowledges each byte by pulling data low on ninth pulse.
// R12: Receiver refusing a byte leaves data high on ninth pulse.
// R13: Port gives read and write access to all configuration registers.
// R14: Port keeps working while the sleep pin is low.
// R15: Registers keep contents through sleep; writes during sleep take.
// R16: First byte after start is address plus direction, 0 write 1 read.
// R17: Write: two register address bytes high first, then data bytes.
// R18: Read without address phase starts at the current register address.
// R19: Start or stop honoured anywhere; partial bytes are discarded.
// R20: Register address increments after each data byte.
// R21: Only the selected one of the two ports responds.
`timescale 1ns/1ns
module spsi_serial_port #(
  parameter int CFG_ADDR_W = spsi_pkg::CFG_ADDR_W_DEF
) (
  // System clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Two-wire bus
  input  wire logic        scl_clk,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  // Straps and sleep pin
  input  wire logic [1:0]  port_select_pin_hi,
  input  wire logic [1:0]  port_select_pin_lo,
  input  wire logic        chip_sleep_pin_n,
  // Status to the chip
  output logic             four_wire_en,
  output logic             sleep_active,
  // Register update stream to the chip
  output logic             cfg_wr_stb,
  output logic [15:0]      cfg_wr_addr,
  output logic [7:0]       cfg_wr_data
);

  if (CFG_ADDR_W < 1 || CFG_ADDR_W > spsi_pkg::REG_ADDR_W)
  begin : g_chk_addr
    $error("spsi_serial_port: CFG_ADDR_W out of range");
  end

  // Fetch must land inside the shortest half bit
  if (spsi_pkg::FETCH_LAT_CYC >= spsi_pkg::FAST_HALF_CYC)
  begin : g_chk_rate
    $error("spsi_serial_port: fetch too slow for fast rate"); // R3
  end

  // Clock-domain side
  logic [1:0]  pin_hi_s;
  logic [1:0]  pin_lo_s;
  logic        sleep_n_s;
  logic [1:0]  req_s;
  logic [1:0]  req_last_q;
  logic        wr_go;
  logic        fetch_go;
  logic        wr_in_range;
  logic [2:0]  addr_lsb;
  logic        four_wire_d;
  logic [6:0]  own_addr_q;
  logic [7:0]  mem_rd_data;

  // Link side
  logic                  start_tgl_q;
  logic                  stop_tgl_q;
  logic                  start_seen_q;
  logic                  stop_seen_q;
  logic                  start_new;
  logic                  stop_new;
  spsi_pkg::spsi_state_t state_q;
  spsi_pkg::spsi_state_t state_d;
  logic [2:0]            bit_cnt_q;
  logic [2:0]            bit_cnt_d;
  logic [7:0]            shift_q;
  logic [7:0]            rx_byte;
  logic                  byte_end;
  logic                  addr_match;
  logic                  addr_hit;
  logic                  rw_q;
  logic [1:0]            byte_idx_q;
  logic [7:0]            addr_hi_q;
  logic [15:0]           ptr_q;
  logic                  rx_done;
  logic                  take_hi;
  logic                  take_lo;
  logic                  take_data;
  logic                  tx_step;
  logic                  fetch_tgl_q;
  logic                  wr_tgl_q;
  logic [15:0]           wr_addr_q;
  logic [7:0]            wr_data_q;
  logic [7:0]            txsh_q;
  logic                  tx_load;
  logic                  tx_bit;
  logic                  drive_low;

  // ---------------- System clock domain ----------------

  spsi_sync #(
    .WIDTH (5)
  ) u_sync_pins (
    .clk (clk),
    .rst (rst),
    .d   ({port_select_pin_hi, port_select_pin_lo, chip_sleep_pin_n}),
    .q   ({pin_hi_s, pin_lo_s, sleep_n_s})
  );

  spsi_sync #(
    .WIDTH (2)
  ) u_sync_req (
    .clk (clk),
    .rst (rst),
    .d   ({wr_tgl_q, fetch_tgl_q}),
    .q   (req_s)
  );

  assign wr_go       = req_s[1] ^ req_last_q[1];
  assign fetch_go    = req_s[0] ^ req_last_q[0];
  assign wr_in_range = (wr_addr_q >> CFG_ADDR_W) == 16'h0000;
  assign four_wire_d = (pin_hi_s == spsi_pkg::PIN_HIGH) &&
                       (pin_lo_s == spsi_pkg::PIN_HIGH); // R1
  assign addr_lsb    = ({1'b0, pin_hi_s} << 1) + {1'b0, pin_hi_s} +
                       {1'b0, pin_lo_s}; // R2

  // Stored settings are untouched by the sleep pin
  spsi_cfg_mem #(
    .ADDR_W (CFG_ADDR_W)
  ) u_mem (
    .clk     (clk),
    .rst     (rst),
    .wr_en   (wr_go && wr_in_range), // R13 R15
    .wr_addr (wr_addr_q[CFG_ADDR_W-1:0]),
    .wr_data (wr_data_q),
    .rd_en   (fetch_go), // R13
    .rd_addr (ptr_q[CFG_ADDR_W-1:0]),
    .rd_data (mem_rd_data)
  );

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      req_last_q   <= 2'h0;
      four_wire_en <= 1'b0;
      own_addr_q   <= 7'h00;
      sleep_active <= 1'b0;
      sda_o        <= 1'b0;
    end
    else
    begin
      req_last_q   <= req_s;
      four_wire_en <= four_wire_d; // R21
      own_addr_q   <= {spsi_pkg::SLAVE_ADDR_TOP, addr_lsb}; // R2
      sleep_active <= ~sleep_n_s; // R14
      sda_o        <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cfg_wr_stb  <= 1'b0;
      cfg_wr_addr <= 16'h0000;
      cfg_wr_data <= 8'h00;
    end
    else
    begin
      cfg_wr_stb <= wr_go && wr_in_range; // R15
      if (wr_go)
      begin
        cfg_wr_addr <= wr_addr_q;
        cfg_wr_data <= wr_data_q;
      end
    end
  end

  // ---------------- Link side ----------------

  // Start: data falls with clock high
  always_ff @(negedge sda_i or posedge rst)
  begin
    if (rst)
      start_tgl_q <= 1'b0;
    else if (scl_clk)
      start_tgl_q <= ~start_tgl_q; // R8 R19
  end

  // Stop: data rises with clock high
  always_ff @(posedge sda_i or posedge rst)
  begin
    if (rst)
      stop_tgl_q <= 1'b0;
    else if (scl_clk)
      stop_tgl_q <= ~stop_tgl_q; // R9 R19
  end

  // Toggles settle a full hold time before the next clock rise
  assign start_new  = start_tgl_q ^ start_seen_q;
  assign stop_new   = stop_tgl_q ^ stop_seen_q;
  assign rx_byte    = {shift_q[6:0], sda_i}; // R6 R10
  assign byte_end   = bit_cnt_q == spsi_pkg::LAST_BIT;
  assign addr_match = (rx_byte[7:1] == own_addr_q) && !four_wire_en; // R21
  assign addr_hit   = state_q == spsi_pkg::ST_ADDR && byte_end &&
                      !start_new && !stop_new;
  assign rx_done    = state_q == spsi_pkg::ST_RX && byte_end &&
                      !start_new && !stop_new; // R19
  assign take_hi    = rx_done && byte_idx_q == spsi_pkg::IDX_ADDR_HI;
  assign take_lo    = rx_done && byte_idx_q == spsi_pkg::IDX_ADDR_LO;
  assign take_data  = rx_done && byte_idx_q == spsi_pkg::IDX_DATA;
  assign tx_step    = state_q == spsi_pkg::ST_MACK &&
                      !start_new && !stop_new;

  always_comb
  begin
    state_d   = state_q;
    bit_cnt_d = bit_cnt_q + 3'h1;
    if (start_new)
    begin
      state_d   = spsi_pkg::ST_ADDR; // R8
      bit_cnt_d = 3'h1;
    end
    else if (stop_new)
    begin
      state_d   = spsi_pkg::ST_IDLE; // R9
      bit_cnt_d = spsi_pkg::FIRST_BIT;
    end
    else
    begin
      case (state_q)
        spsi_pkg::ST_ADDR:
          if (byte_end)
            state_d = addr_match ? spsi_pkg::ST_ACK : spsi_pkg::ST_IDLE;
        spsi_pkg::ST_ACK:
        begin
          state_d   = rw_q ? spsi_pkg::ST_TX : spsi_pkg::ST_RX; // R16
          bit_cnt_d = spsi_pkg::FIRST_BIT;
        end
        spsi_pkg::ST_RX:
          if (byte_end)
            state_d = spsi_pkg::ST_ACK;
        spsi_pkg::ST_TX:
          if (byte_end)
            state_d = spsi_pkg::ST_MACK;
        spsi_pkg::ST_MACK:
        begin
          state_d   = sda_i ? spsi_pkg::ST_IDLE : spsi_pkg::ST_TX; // R11 R12
          bit_cnt_d = spsi_pkg::FIRST_BIT;
        end
        spsi_pkg::ST_IDLE:
          bit_cnt_d = spsi_pkg::FIRST_BIT;
        default:
        begin
          state_d   = spsi_pkg::ST_IDLE;
          bit_cnt_d = spsi_pkg::FIRST_BIT;
        end
      endcase
    end
  end

  always_ff @(posedge scl_clk or posedge rst)
  begin
    if (rst)
    begin
      start_seen_q <= 1'b0;
      stop_seen_q  <= 1'b0;
      state_q      <= spsi_pkg::ST_IDLE;
      bit_cnt_q    <= spsi_pkg::FIRST_BIT;
      shift_q      <= 8'h00;
    end
    else
    begin
      start_seen_q <= start_tgl_q;
      stop_seen_q  <= stop_tgl_q;
      state_q      <= state_d;
      bit_cnt_q    <= bit_cnt_d; // R6
      shift_q      <= rx_byte; // R10
    end
  end

  always_ff @(posedge scl_clk or posedge rst)
  begin
    if (rst)
    begin
      rw_q       <= 1'b0;
      byte_idx_q <= spsi_pkg::IDX_ADDR_HI;
      addr_hi_q  <= 8'h00;
    end
    else if (addr_hit)
    begin
      rw_q       <= rx_byte[0]; // R16
      byte_idx_q <= spsi_pkg::IDX_ADDR_HI;
    end
    else if (rx_done)
    begin
      if (take_hi)
        addr_hi_q <= rx_byte; // R5 R17
      if (!take_data)
        byte_idx_q <= byte_idx_q + 2'h1;
    end
  end

  // Pointer and requests toward the register store
  always_ff @(posedge scl_clk or posedge rst)
  begin
    if (rst)
    begin
      ptr_q       <= spsi_pkg::PTR_RESET;
      fetch_tgl_q <= 1'b0;
      wr_tgl_q    <= 1'b0;
      wr_addr_q   <= 16'h0000;
      wr_data_q   <= 8'h00;
    end
    else
    begin
      if (take_lo)
        ptr_q <= {addr_hi_q, rx_byte}; // R5 R17
      else if (take_data || tx_step)
        ptr_q <= ptr_q + 16'h0001; // R20
      if (take_lo || take_data || tx_step)
        fetch_tgl_q <= ~fetch_tgl_q; // R18
      if (take_data)
      begin
        wr_addr_q <= ptr_q; // R17
        wr_data_q <= rx_byte;
        wr_tgl_q  <= ~wr_tgl_q;
      end
    end
  end

  // Drive side, changed only on the falling clock edge
  assign tx_load   = state_q == spsi_pkg::ST_TX &&
                     bit_cnt_q == spsi_pkg::FIRST_BIT;
  assign tx_bit    = tx_load ? mem_rd_data[7] : txsh_q[6]; // R10
  assign drive_low = (state_q == spsi_pkg::ST_ACK) || // R11
                     (state_q == spsi_pkg::ST_TX && !tx_bit);

  // Clock line is never driven; only data is pulled low
  always_ff @(negedge scl_clk or posedge rst)
  begin
    if (rst)
    begin
      txsh_q <= 8'h00;
      sda_oe <= 1'b0;
    end
    else
    begin
      txsh_q <= tx_load ? mem_rd_data : {txsh_q[6:0], 1'b0};
      sda_oe <= drive_low; // R4 R7 R12
    end
  end

endmodule

/* File: tb/spsi_serial_port_assertions.sv */
// Port checker for the serial port select and two-wire slave
`timescale 1ns/1ns
module spsi_serial_port_assertions #(
  parameter int CFG_ADDR_W = spsi_pkg::CFG_ADDR_W_DEF
) (
  // Clocks and reset
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        scl_clk,
  // Data line
  input wire logic        sda_i,
  input wire logic        sda_o,
  input wire logic        sda_oe,
  // Straps and sleep pin
  input wire logic [1:0]  port_select_pin_hi,
  input wire logic [1:0]  port_select_pin_lo,
  input wire logic        chip_sleep_pin_n,
  // Status and write stream
  input wire logic        four_wire_en,
  input wire logic        sleep_active,
  input wire logic        cfg_wr_stb,
  input wire logic [15:0] cfg_wr_addr,
  input wire logic [7:0]  cfg_wr_data
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic both_hi;
  assign both_hi = port_select_pin_hi == spsi_pkg::PIN_HIGH
                && port_select_pin_lo == spsi_pkg::PIN_HIGH;

  a_drive_only_low: assert property (sda_o == 1'b0)
    else $error("data drive value not low");
  a_oe_scl_high: assert property (
    scl_clk && $past(scl_clk) |-> $stable(sda_oe))
    else $error("data enable moved while clock high");
  a_stb_one_cycle: assert property (cfg_wr_stb |=> !cfg_wr_stb)
    else $error("write strobe longer than one cycle");
  a_stb_in_range: assert property (
    cfg_wr_stb |-> (cfg_wr_addr >> CFG_ADDR_W) == 16'h0000)
    else $error("write strobe for unmapped register");
  a_stb_value_holds: assert property (
    cfg_wr_stb |=> ($stable(cfg_wr_addr) && $stable(cfg_wr_data))[*8])
    else $error("write address or data moved too soon");
  a_four_wire_quiet: assert property (four_wire_en |-> !sda_oe)
    else $error("two-wire slave drove data in four-wire mode");
  a_four_wire_on: assert property (both_hi[*4] |-> four_wire_en)
    else $error("four-wire mode not selected");
  a_four_wire_off: assert property ((!both_hi)[*4] |-> !four_wire_en)
    else $error("four-wire mode selected wrongly");
  a_sleep_flag: assert property ((!chip_sleep_pin_n)[*4] |-> sleep_active)
    else $error("sleep flag missing");
endmodule

/* File: tb/spsi_master.sv */
// Behavioural two-wire bus master, open-drain on the data line
`timescale 1ns/1ns
module spsi_master (
  // Bus lines
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda
);
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // One clock pulse per bit, data moved mid-low
  // Long high phase lets the slave fetch the next read byte
  task automatic put_bit(input logic b, output logic s);
    #8 sda_pull = !b;
    #8 scl = 1'b1;
    #40 s = sda;
    #8 scl = 1'b0;
  endtask
  task automatic start();
    #8 sda_pull = 1'b0;
    #8 scl = 1'b1;
    #24 sda_pull = 1'b1;
    #24 scl = 1'b0;
  endtask
  // Clock then stands high until the next frame
  task automatic stop();
    #8 sda_pull = 1'b1;
    #8 scl = 1'b1;
    #24 sda_pull = 1'b0;
    #24;
  endtask
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      put_bit(b[i], s);
    put_bit(1'b1, s);
    ack = !s;
  endtask
  task automatic rd_byte(input logic ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      put_bit(1'b1, s);
      b[i] = s;
    end
    put_bit(!ack, s);
  endtask
endmodule

/* File: tb/test_serial_port_select_i2c_slave.sv */
// Self-checking bench for the two-wire register slave
`timescale 1ns/1ns
module test_serial_port_select_i2c_slave;
  localparam int AW = 4;
  localparam logic [6:0] SA = 7'h5d;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        sleep_n = 1'b1;
  logic [1:0]  sel_hi = 2'h0;
  logic [1:0]  sel_lo = 2'h0;
  logic        scl, pull, sda, sda_o, sda_oe, four_wire_en, sleep_active;
  logic        cfg_wr_stb, ack;
  logic [15:0] cfg_wr_addr;
  logic [7:0]  cfg_wr_data, rb;
  logic [7:0]  mem [int];
  logic [23:0] got [$];
  logic [23:0] want [$];
  int          n_mismatch = 0, comparisons = 0, cycles = 0, ptr = 0;

  always #5 clk = ~clk;
  assign sda = !(pull | sda_oe);

  spsi_serial_port #(.CFG_ADDR_W(AW)) dut (
    .clk(clk), .rst(rst), .scl_clk(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .port_select_pin_hi(sel_hi),
    .port_select_pin_lo(sel_lo), .chip_sleep_pin_n(sleep_n),
    .four_wire_en(four_wire_en), .sleep_active(sleep_active),
    .cfg_wr_stb(cfg_wr_stb), .cfg_wr_addr(cfg_wr_addr),
    .cfg_wr_data(cfg_wr_data));
  spsi_master m (.scl(scl), .sda_pull(pull), .sda(sda));

  always @(posedge clk)
    if (cfg_wr_stb === 1'b1)
      got.push_back({cfg_wr_addr, cfg_wr_data});
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic cmp(input logic [23:0] g, input logic [23:0] e);
    comparisons++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmp_bit(input logic g, input logic e);
    cmp({23'h0, g}, {23'h0, e});
  endtask
  task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
    cmp({16'h0, g}, {16'h0, e});
  endtask
  task automatic cmp_wr(input logic [23:0] g, input logic [23:0] e);
    cmp(g, e);
  endtask

  task automatic set_ptr(input logic [15:0] a);
    m.start();
    m.wr_byte({SA, 1'b0}, ack);
    cmp_bit(ack, 1'b1);
    m.wr_byte(a[15:8], ack);
    cmp_bit(ack, 1'b1);
    m.wr_byte(a[7:0], ack);
    cmp_bit(ack, 1'b1);
    ptr = a;
  endtask
  task automatic wr_data(input int n);
    logic [7:0] d;
    repeat (n)
    begin
      d = 8'($urandom);
      m.wr_byte(d, ack);
      cmp_bit(ack, 1'b1);
      if (ptr < 2 ** AW)
      begin
        mem[ptr] = d;
        want.push_back({16'(ptr), d});
      end
      ptr = (ptr + 1) % 65536;
    end
    m.stop();
  endtask
  task automatic rd_data(input int n);
    int k;
    m.start();
    m.wr_byte({SA, 1'b1}, ack);
    cmp_bit(ack, 1'b1);
    for (int i = 1; i <= n; i++)
    begin
      k = ptr % (2 ** AW);
      m.rd_byte(i < n, rb);
      cmp_byte(rb, mem.exists(k) ? mem[k] : 8'h00);
      ptr = (ptr + 1) % 65536;
    end
    m.stop();
  endtask
  task automatic chk_wr();
    repeat (20) @(posedge clk);
    cmp_bit(got.size() == want.size(), 1'b1);
    while (got.size() > 0 && want.size() > 0)
      cmp_wr(got.pop_front(), want.pop_front());
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    void'($urandom(32'hf916));
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    for (int h = 0; h < 3; h++)
      for (int l = 0; l < 3; l++)
      begin
        @(posedge clk);
        #1 sel_hi = 2'(h);
        sel_lo = 2'(l);
        repeat (8) @(posedge clk);
        cmp_bit(four_wire_en, h == 2 && l == 2);
        for (int k = 0; k < 8; k++)
        begin
          m.start();
          m.wr_byte({4'hb, 3'(k), 1'b0}, ack);
          cmp_bit(ack, k == h * 3 + l);
          m.stop();
        end
      end
    $display("test strap addresses done");
    @(posedge clk);
    #1 sel_hi = spsi_pkg::PIN_OPEN;
    sel_lo = spsi_pkg::PIN_HIGH;
    repeat (8) @(posedge clk);
    set_ptr(16'(2 ** AW - 2));
    wr_data(3);
    chk_wr();
    set_ptr(16'(2 ** AW - 2));
    rd_data(3);
    rd_data(2);
    $display("test burst and read back done");
    @(posedge clk);
    #1 sleep_n = 1'b0;
    repeat (8) @(posedge clk);
    cmp_bit(sleep_active, 1'b1);
    set_ptr(16'h0005);
    wr_data(2);
    chk_wr();
    @(posedge clk);
    #1 sleep_n = 1'b1;
    set_ptr(16'h0005);
    rd_data(2);
    $display("test sleep access done");
    set_ptr(16'h0003);
    for (int i = 0; i < 4; i++)
      m.put_bit(1'b1, ack);
    m.stop();
    chk_wr();
    rd_data(2);
    $display("test partial byte done");
    test_done();
  end
endmodule

bind spsi_serial_port spsi_serial_port_assertions #(
  .CFG_ADDR_W(CFG_ADDR_W)
) u_chk (
  .clk(clk), .rst(rst), .scl_clk(scl_clk), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe(sda_oe), .port_select_pin_hi(port_select_pin_hi),
  .port_select_pin_lo(port_select_pin_lo),
  .chip_sleep_pin_n(chip_sleep_pin_n), .four_wire_en(four_wire_en),
  .sleep_active(sleep_active), .cfg_wr_stb(cfg_wr_stb),
  .cfg_wr_addr(cfg_wr_addr), .cfg_wr_data(cfg_wr_data));
